// *** hdl/ldm_pkg.sv ***
// ldm_pkg: shared constants for the led digit memory link
// assumes a 25 MHz system clock on both ends
package ldm_pkg;
    // link addressing
    localparam logic [2:0] SLAVE_ADDR_HI = 3'b110;
    // command addresses
    localparam logic [6:0] REG_DECODE  = 7'h01;
    localparam logic [6:0] REG_CONFIG  = 7'h04;
    localparam logic [6:0] REG_KIND    = 7'h0C;
    localparam logic [6:0] REG_FACTORY = 7'h0D;
    localparam logic [6:0] PTR_HOLD    = 7'h7F;
    // digit pages: bit 5 plane zero, bit 6 plane one, bit 4 must be 0
    localparam int DIG_PLANE0_BIT = 5;
    localparam int DIG_PLANE1_BIT = 6;
    localparam int DIG_GAP_BIT = 4;
    localparam int DIGITS      = 16;
    // configuration fields
    localparam int CFG_S = 0;
    localparam int CFG_B = 2;
    localparam int CFG_E = 3;
    localparam int CFG_T = 4;
    localparam int CFG_R = 5;
    localparam int CFG_I = 6;
    localparam int CFG_P = 7;
    localparam logic [7:0] CFG_STORED_MASK = 8'h4D;
    // reset values
    localparam logic [7:0] CFG_RESET    = 8'h00;
    localparam logic [7:0] DECODE_RESET = 8'h00;
    localparam logic [7:0] KIND_RESET   = 8'h00;
    localparam logic [7:0] DIGIT_BLANK  = 8'h20;
    // font
    localparam logic [6:0] HEX_BLANK        = 7'h10;
    localparam logic [6:0] FONT_HEX_COUNT   = 7'h10;
    localparam logic [6:0] FONT_ASCII_FIRST = 7'h28;
    localparam logic [6:0] HEX_FONT [16] = '{7'h7E, 7'h30, 7'h6D, 7'h79, 7'h33, 7'h5B, 7'h5F, 7'h70,
                                             7'h7F, 7'h7B, 7'h77, 7'h1F, 7'h4E, 7'h3D, 7'h4F, 7'h47};
    // blink timing in multiplex clock edges per phase
    localparam int MUX_CLK_REF_HZ         = 4000000;
    localparam int BLINK_SLOW_PHASE_EDGES = MUX_CLK_REF_HZ;
    localparam int BLINK_FAST_PHASE_EDGES = MUX_CLK_REF_HZ / 2;
    localparam int BLK_W                  = 23;
    // master bit timing
    localparam int CLK_HZ      = 25000000;
    localparam int SCL_HZ      = 100000;
    localparam int SCL_QTR_CYC = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
    localparam int QTR_W       = 7;
endpackage : ldm_pkg

// *** hdl/ldm_link_if.sv ***
// ldm_link_if: open-drain two-wire link between master and display device
// assumes pull-ups on both wires, modelled as a wired and
`timescale 1ns/100ps
interface ldm_link_if;
    logic scl;
    logic sda;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    // wire levels from the enables
    assign scl = host_scl_oe ? host_scl_o : 1'b1;
    assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface : ldm_link_if

// *** hdl/ldm_device.sv ***
// ldm_device: two-wire slave, digit memory, configuration and font select
// assumes link wires and multiplex clock sampled synchronous to clock
`timescale 1ns/100ps
// Overview of operation
// - low address bits from two strap codes
// - answer only slave address 110 plus straps
// - master uses repeated start before reads
// - reads continue until nack or stop
// - pointer increments after every data byte
// - pointer 7F holds, never wraps
// - master never writes address 0D
// - two planes, writable singly or together
// - blink off shows plane zero only
// - blink on alternates planes per phase
// - low seven bits pick glyph, D7 dp
// - per pair decode bit: hex or direct
// - hex code 10 blanks the digit
// - slot kind bits per cathode output
// - slot kind register is write only
// - blink by writing blank in other plane
// - blink rate bit picks fast or slow
// - reset: controls cleared, blank, shutdown
// - stored config bits read back as written
// - timing reset bit restarts blink timing
// - clear bit blanks both planes everywhere
// - phase bit read only, shows phase
// - font: hex set plus ascii, 104 glyphs
module ldm_device import ldm_pkg::*; #(
    parameter int BLINK_SLOW = BLINK_SLOW_PHASE_EDGES, // edges per slow phase
    parameter int BLINK_FAST = BLINK_FAST_PHASE_EDGES  // edges per fast phase
) (
    input  wire logic       clock,              // system clock
    input  wire logic       srst,               // sync reset
    input  wire logic       ce,                 // clock enable
    ldm_link_if.dev         link,               // two-wire link
    input  wire logic [1:0] addr_strap_high,    // strap code a3 a2
    input  wire logic [1:0] addr_strap_low,     // strap code a1 a0
    input  wire logic       multiplex_clock_in, // blink time base
    input  wire logic [3:0] digit_sel,          // digit being scanned
    output logic      [7:0] seg_pattern_r,      // 7-seg segments, dp bit 7
    output logic      [6:0] font_index_r,       // glyph index
    output logic            font_valid_r,       // glyph shown, else blank
    output logic            char_mode_r,        // digit uses glyph font
    output logic            dp_r,               // decimal_point_segment
    output logic            display_on,         // 0 while shutdown
    output logic            intensity_mode,     // per digit intensity
    output logic            blink_phase,        // current blink phase
    output logic      [7:0] slot_kind           // slot_display_kind
);
    typedef enum {ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK} ldm_st_type;

    ldm_st_type       st_r, st_nxt, after_r, after_nxt;
    logic       [3:0] bit_r, bit_nxt;
    logic       [7:0] sh_r, sh_nxt, tx_r, tx_nxt, tx_shift;
    logic       [6:0] ptr_r, ptr_nxt, ptr_adv;
    logic             scl_q_r, sda_q_r, oe_r, oe_nxt, nack_r, nack_nxt;
    logic       [3:0] strap_r;
    logic             scl_rise, scl_fall, start_c, stop_c, wr_en;
    logic       [7:0] rd_data;
    logic       [7:0] cfg_r, cfg_nxt, dec_r, dec_nxt, kind_r, kind_nxt;
    logic             t_pulse, r_pulse;
    logic       [7:0] p0_r [DIGITS];
    logic       [7:0] p1_r [DIGITS];
    logic [BLK_W-1:0] cnt_r, cnt_nxt, lim;
    logic             ph_r, ph_nxt, mclk_q_r, mclk_rise;
    logic       [7:0] sel_byte, seg_nxt;
    logic       [6:0] fidx_nxt;
    logic             fval_nxt, char_nxt, dp_nxt;

    // link conditions
    assign scl_rise  = link.scl & ~scl_q_r;
    assign scl_fall  = ~link.scl & scl_q_r;
    assign start_c   = link.scl & scl_q_r & sda_q_r & ~link.sda;
    assign stop_c    = link.scl & scl_q_r & ~sda_q_r & link.sda;
    assign ptr_adv   = (ptr_r == PTR_HOLD) ? ptr_r : 7'(ptr_r + 7'h01);
    assign tx_shift  = tx_r << bit_r;
    assign link.dev_sda_o  = 1'b0;
    assign link.dev_sda_oe = oe_r;

    // read data at the pointer
    always_comb begin
        rd_data = 8'h00;
        if (ptr_r == REG_DECODE) begin
            rd_data = dec_r;
        end else if (ptr_r == REG_CONFIG) begin
            rd_data = {ph_r, cfg_r[6:0]};
        end else if (!ptr_r[DIG_GAP_BIT] && ptr_r[DIG_PLANE0_BIT]) begin
            rd_data = p0_r[ptr_r[3:0]];
        end else if (!ptr_r[DIG_GAP_BIT] && ptr_r[DIG_PLANE1_BIT]) begin
            rd_data = p1_r[ptr_r[3:0]];
        end
    end

    // serial engine next state
    always_comb begin
        st_nxt    = st_r;
        after_nxt = after_r;
        bit_nxt   = bit_r;
        sh_nxt    = sh_r;
        tx_nxt    = tx_r;
        ptr_nxt   = ptr_r;
        oe_nxt    = oe_r;
        nack_nxt  = nack_r;
        wr_en     = 1'b0;
        if (start_c) begin
            st_nxt  = ST_ADDR;
            bit_nxt = 4'h0;
            oe_nxt  = 1'b0;
        end else if (stop_c) begin
            st_nxt = ST_IDLE;
            oe_nxt = 1'b0;
        end else if (scl_rise) begin
            case (st_r)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    sh_nxt  = {sh_r[6:0], link.sda};
                    bit_nxt = 4'(bit_r + 4'h1);
                end
                ST_RDATA: bit_nxt  = 4'(bit_r + 4'h1);
                ST_RACK:  nack_nxt = link.sda;
                default: ;
            endcase
        end else if (scl_fall) begin
            case (st_r)
                ST_ADDR: if (bit_r == 4'h8) begin
                    if (sh_r[7:1] == {SLAVE_ADDR_HI, strap_r}) begin
                        oe_nxt    = 1'b1;
                        after_nxt = sh_r[0] ? ST_RDATA : ST_CMD;
                        st_nxt    = ST_ACK;
                    end else begin
                        st_nxt = ST_IDLE;
                    end
                end
                ST_CMD: if (bit_r == 4'h8) begin
                    ptr_nxt   = sh_r[6:0];
                    oe_nxt    = 1'b1;
                    after_nxt = ST_WDATA;
                    st_nxt    = ST_ACK;
                end
                ST_WDATA: if (bit_r == 4'h8) begin
                    wr_en   = 1'b1;
                    ptr_nxt = ptr_adv;
                    oe_nxt  = 1'b1;
                    st_nxt  = ST_ACK;
                end
                ST_ACK: begin
                    bit_nxt = 4'h0;
                    st_nxt  = after_r;
                    oe_nxt  = 1'b0;
                    if (after_r == ST_RDATA) begin
                        tx_nxt  = rd_data;
                        ptr_nxt = ptr_adv;
                        oe_nxt  = ~rd_data[7];
                    end
                end
                ST_RDATA: begin
                    if (bit_r == 4'h8) begin
                        oe_nxt = 1'b0;
                        st_nxt = ST_RACK;
                    end else begin
                        oe_nxt = ~tx_shift[7];
                    end
                end
                ST_RACK: begin
                    bit_nxt = 4'h0;
                    if (nack_r) begin
                        st_nxt = ST_IDLE;
                    end else begin
                        tx_nxt  = rd_data;
                        ptr_nxt = ptr_adv;
                        oe_nxt  = ~rd_data[7];
                        st_nxt  = ST_RDATA;
                    end
                end
                default: ;
            endcase
        end
    end

    // serial engine registers
    always_ff @(posedge clock) begin
        if (srst) begin
            st_r    <= ST_IDLE;
            after_r <= ST_IDLE;
            bit_r   <= 4'h0;
            sh_r    <= 8'h00;
            tx_r    <= 8'h00;
            ptr_r   <= 7'h00;
            oe_r    <= 1'b0;
            nack_r  <= 1'b0;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            strap_r <= {addr_strap_high, addr_strap_low};
        end else if (ce) begin
            st_r    <= st_nxt;
            after_r <= after_nxt;
            bit_r   <= bit_nxt;
            sh_r    <= sh_nxt;
            tx_r    <= tx_nxt;
            ptr_r   <= ptr_nxt;
            oe_r    <= oe_nxt;
            nack_r  <= nack_nxt;
            scl_q_r <= link.scl;
            sda_q_r <= link.sda;
        end
    end

    // control register writes; factory address ignored
    always_comb begin
        cfg_nxt  = cfg_r;
        dec_nxt  = dec_r;
        kind_nxt = kind_r;
        t_pulse  = 1'b0;
        r_pulse  = 1'b0;
        if (wr_en && ptr_r != REG_FACTORY) begin
            case (ptr_r)
                REG_DECODE: dec_nxt = sh_r;
                REG_CONFIG: begin
                    cfg_nxt = sh_r & CFG_STORED_MASK;
                    t_pulse = sh_r[CFG_T];
                    r_pulse = sh_r[CFG_R];
                end
                REG_KIND: kind_nxt = sh_r;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cfg_r  <= CFG_RESET;
            dec_r  <= DECODE_RESET;
            kind_r <= KIND_RESET;
        end else if (ce) begin
            cfg_r  <= cfg_nxt;
            dec_r  <= dec_nxt;
            kind_r <= kind_nxt;
        end
    end

    // digit memory, one entry per digit in each plane
    for (genvar i = 0; i < DIGITS; i++) begin : g_dig
        logic [7:0] p0_nxt, p1_nxt;
        logic       hit;
        always_comb begin
            p0_nxt = p0_r[i];
            p1_nxt = p1_r[i];
            hit    = wr_en && !ptr_r[DIG_GAP_BIT] && ptr_r[3:0] == 4'(i);
            if (r_pulse) begin
                p0_nxt = DIGIT_BLANK;
                p1_nxt = DIGIT_BLANK;
            end else begin
                if (hit && ptr_r[DIG_PLANE0_BIT]) p0_nxt = sh_r;
                if (hit && ptr_r[DIG_PLANE1_BIT]) p1_nxt = sh_r;
            end
        end
        always_ff @(posedge clock) begin
            if (srst) begin
                p0_r[i] <= DIGIT_BLANK;
                p1_r[i] <= DIGIT_BLANK;
            end else if (ce) begin
                p0_r[i] <= p0_nxt;
                p1_r[i] <= p1_nxt;
            end
        end
    end

    // blink timing, halted while shut down
    assign mclk_rise = multiplex_clock_in & ~mclk_q_r;
    assign lim = cfg_r[CFG_B] ? BLK_W'(BLINK_FAST - 1) : BLK_W'(BLINK_SLOW - 1);
    always_comb begin
        cnt_nxt = cnt_r;
        ph_nxt  = ph_r;
        if (t_pulse) begin
            cnt_nxt = '0;
            ph_nxt  = 1'b0;
        end else if (mclk_rise && cfg_r[CFG_S]) begin
            if (cnt_r >= lim) begin
                cnt_nxt = '0;
                ph_nxt  = ~ph_r;
            end else begin
                cnt_nxt = BLK_W'(cnt_r + 1'b1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_r    <= '0;
            ph_r     <= 1'b0;
            mclk_q_r <= 1'b0;
        end else if (ce) begin
            cnt_r    <= cnt_nxt;
            ph_r     <= ph_nxt;
            mclk_q_r <= multiplex_clock_in;
        end
    end

    // digit decode for the scanned digit
    assign sel_byte = (cfg_r[CFG_E] && ph_r) ? p1_r[digit_sel] : p0_r[digit_sel];
    always_comb begin
        seg_nxt  = 8'h00;
        fidx_nxt = 7'h00;
        fval_nxt = 1'b0;
        dp_nxt   = 1'b0;
        char_nxt = kind_r[digit_sel[2:0]];
        if (!cfg_r[CFG_S]) begin
            seg_nxt = 8'h00;
        end else if (char_nxt) begin
            dp_nxt = sel_byte[7];
            if (sel_byte[6:0] < FONT_HEX_COUNT) begin
                fidx_nxt = sel_byte[6:0];
                fval_nxt = 1'b1;
            end else if (sel_byte[6:0] >= FONT_ASCII_FIRST) begin
                fidx_nxt = 7'(sel_byte[6:0] - FONT_ASCII_FIRST + FONT_HEX_COUNT);
                fval_nxt = 1'b1;
            end
        end else if (dec_r[digit_sel[2:0]]) begin
            dp_nxt = sel_byte[7];
            if (sel_byte[6:0] != HEX_BLANK) begin
                seg_nxt = {sel_byte[7], HEX_FONT[sel_byte[3:0]]};
            end else begin
                seg_nxt = {sel_byte[7], 7'h00};
            end
        end else begin
            seg_nxt = sel_byte;
            dp_nxt  = sel_byte[7];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            seg_pattern_r <= 8'h00;
            font_index_r  <= 7'h00;
            font_valid_r  <= 1'b0;
            char_mode_r   <= 1'b0;
            dp_r          <= 1'b0;
        end else if (ce) begin
            seg_pattern_r <= seg_nxt;
            font_index_r  <= fidx_nxt;
            font_valid_r  <= fval_nxt;
            char_mode_r   <= char_nxt;
            dp_r          <= dp_nxt;
        end
    end

    assign display_on     = cfg_r[CFG_S];
    assign intensity_mode = cfg_r[CFG_I];
    assign blink_phase    = ph_r;
    assign slot_kind      = kind_r;
endmodule : ldm_device

// *** hdl/ldm_host.sv ***
// ldm_host: two-wire master doing single byte register writes and reads
// assumes the device answers within normal bit timing, no clock stretch
`timescale 1ns/100ps
module ldm_host import ldm_pkg::*; (
    input  wire logic       clock,      // system clock
    input  wire logic       srst,       // sync reset
    input  wire logic       ce,         // clock enable
    ldm_link_if.host        link,       // two-wire link
    input  wire logic       cmd_valid,  // request present
    output logic            cmd_ready,  // request taken
    input  wire logic       cmd_read,   // 1 read, 0 write
    input  wire logic [6:0] cmd_slave,  // slave address
    input  wire logic [7:0] cmd_reg,    // command byte
    input  wire logic [7:0] cmd_wdata,  // write data
    output logic            rsp_valid_r,// transfer done pulse
    output logic      [7:0] rsp_data_r, // read data
    output logic            rsp_nack_r  // a byte was not acked
);
    typedef enum {H_IDLE, H_START, H_BIT, H_STOP} ldm_hst_type;

    ldm_hst_type      st_r, st_nxt;
    logic [QTR_W-1:0] q_r, q_nxt;
    logic       [1:0] ph_r, ph_nxt, byte_r, byte_nxt;
    logic       [3:0] bit_r, bit_nxt;
    logic             scl_low_r, scl_low_nxt, sda_low_r, sda_low_nxt;
    logic             rd_r, rd_nxt, nack_nxt, vld_nxt;
    logic       [6:0] slave_r, slave_nxt;
    logic       [7:0] reg_r, reg_nxt, wd_r, wd_nxt, rx_nxt, tx, tx_sh;
    logic             tick, rx_byte;

    assign tick      = (q_r == QTR_W'(SCL_QTR_CYC - 1));
    assign cmd_ready = (st_r == H_IDLE);
    assign rx_byte   = rd_r && byte_r == 2'h3;
    assign tx        = (byte_r == 2'h0) ? {slave_r, 1'b0} : (byte_r == 2'h1) ? reg_r :
                       rd_r ? {slave_r, 1'b1} : wd_r;
    assign tx_sh     = tx << bit_r;
    assign link.host_scl_o  = 1'b0;
    assign link.host_scl_oe = scl_low_r;
    assign link.host_sda_o  = 1'b0;
    assign link.host_sda_oe = sda_low_r;

    // bit sequencer, four quarters per bit
    always_comb begin
        st_nxt = st_r; q_nxt = tick ? '0 : QTR_W'(q_r + 1'b1); ph_nxt = ph_r;
        byte_nxt = byte_r; bit_nxt = bit_r; scl_low_nxt = scl_low_r; sda_low_nxt = sda_low_r;
        rd_nxt = rd_r; slave_nxt = slave_r; reg_nxt = reg_r; wd_nxt = wd_r;
        nack_nxt = rsp_nack_r; rx_nxt = rsp_data_r; vld_nxt = 1'b0;
        if (st_r == H_IDLE) begin
            q_nxt = '0;
            if (cmd_valid) begin
                st_nxt = H_START; ph_nxt = 2'h0; byte_nxt = 2'h0; rd_nxt = cmd_read;
                slave_nxt = cmd_slave; reg_nxt = cmd_reg; wd_nxt = cmd_wdata; nack_nxt = 1'b0;
            end
        end else if (tick) begin
            ph_nxt = 2'(ph_r + 2'h1);
            case (st_r)
                H_START: case (ph_r)
                    2'h0: sda_low_nxt = 1'b0;
                    2'h1: scl_low_nxt = 1'b0;
                    2'h2: sda_low_nxt = 1'b1;
                    default: begin scl_low_nxt = 1'b1; st_nxt = H_BIT; bit_nxt = 4'h0; end
                endcase
                H_BIT: case (ph_r)
                    2'h0: sda_low_nxt = (bit_r < 4'h8) && !rx_byte && !tx_sh[7];
                    2'h1: scl_low_nxt = 1'b0;
                    2'h2: begin
                        if (bit_r < 4'h8 && rx_byte) rx_nxt = {rsp_data_r[6:0], link.sda};
                        if (bit_r == 4'h8 && !rx_byte && link.sda) nack_nxt = 1'b1;
                    end
                    default: begin
                        scl_low_nxt = 1'b1;
                        bit_nxt = 4'(bit_r + 4'h1);
                        if (bit_r == 4'h8) begin
                            bit_nxt = 4'h0;
                            byte_nxt = 2'(byte_r + 2'h1);
                            if (nack_nxt || byte_r == 2'h3 || (!rd_r && byte_r == 2'h2)) st_nxt = H_STOP;
                            else if (rd_r && byte_r == 2'h1) st_nxt = H_START;
                        end
                    end
                endcase
                H_STOP: case (ph_r)
                    2'h0: sda_low_nxt = 1'b1;
                    2'h1: scl_low_nxt = 1'b0;
                    2'h2: sda_low_nxt = 1'b0;
                    default: begin st_nxt = H_IDLE; vld_nxt = 1'b1; end
                endcase
                default: st_nxt = H_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= H_IDLE; q_r <= '0; ph_r <= 2'h0; byte_r <= 2'h0; bit_r <= 4'h0;
            scl_low_r <= 1'b0; sda_low_r <= 1'b0; rd_r <= 1'b0; slave_r <= 7'h00;
            reg_r <= 8'h00; wd_r <= 8'h00; rsp_nack_r <= 1'b0; rsp_data_r <= 8'h00; rsp_valid_r <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt; q_r <= q_nxt; ph_r <= ph_nxt; byte_r <= byte_nxt; bit_r <= bit_nxt;
            scl_low_r <= scl_low_nxt; sda_low_r <= sda_low_nxt; rd_r <= rd_nxt; slave_r <= slave_nxt;
            reg_r <= reg_nxt; wd_r <= wd_nxt; rsp_nack_r <= nack_nxt; rsp_data_r <= rx_nxt;
            rsp_valid_r <= vld_nxt;
        end
    end
endmodule : ldm_host

// *** verif/ldm_link_properties.sv ***
// ldm_link_properties: timing checks on the two-wire link between host and device
// assumes plain copies of the link interface signals and one clock domain
`timescale 1ns/100ps
module ldm_link_properties (
    input wire logic clock,       // system clock
    input wire logic srst,        // sync reset
    input wire logic scl,         // resolved clock wire
    input wire logic sda,         // resolved data wire
    input wire logic host_scl_oe, // host pulls scl
    input wire logic host_sda_oe, // host pulls sda
    input wire logic dev_sda_oe   // device pulls sda
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // device pull-down start and its hold
    sequence s_ack;
        $rose(dev_sda_oe);
    endsequence
    sequence s_ack_held;
        dev_sda_oe [*8];
    endsequence
    // checks
    a_release_idle: assert property ($fell(srst) |-> !host_scl_oe && !host_sda_oe && !dev_sda_oe && scl && sda)
        else $error("link not idle after reset");
    a_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device moved sda while scl high");
    a_ack_delay: assert property (s_ack |-> $past(!scl, 1) && $past(scl, 2))
        else $error("device pulled sda too early");
    a_ack_hold: assert property (s_ack |-> s_ack_held)
        else $error("device pull-down not held");
    a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
        else $error("scl low phase too short");
    a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
        else $error("scl high phase too short");
    a_no_dev_start: assert property (($fell(sda) && scl) |-> !dev_sda_oe)
        else $error("device made a start");
    a_quiet_stop: assert property (($rose(sda) && scl) |=> !dev_sda_oe [*8])
        else $error("device drives after stop");
endmodule : ldm_link_properties

// *** verif/tb_top.sv ***
// tb_top: host and device joined on one link, register traffic checked end to end
// assumes single-byte host transfers and a device strapped to slave 0x69
`timescale 1ns/100ps
module tb_top;
    import ldm_pkg::*;
    logic       clock, srst, cmd_valid, cmd_ready, cmd_read, rsp_valid_r, rsp_nack_r;
    logic [6:0] cmd_slave, font_index_r;
    logic [7:0] cmd_reg, cmd_wdata, rsp_data_r, seg_pattern_r, slot_kind;
    logic       font_valid_r, char_mode_r, dp_r, display_on, intensity_mode, blink_phase;
    logic       ce, mclk;
    logic [3:0] digit_sel;
    int         miscompares = 0;
    int         n_checks    = 0;
    ldm_link_if link ();
    ldm_host i_ldm_host (.clock(clock), .srst(srst), .ce(ce), .link(link), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_slave(cmd_slave), .cmd_reg(cmd_reg),
        .cmd_wdata(cmd_wdata), .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r), .rsp_nack_r(rsp_nack_r));
    ldm_device #(.BLINK_SLOW(4), .BLINK_FAST(2)) i_ldm_device (.clock(clock), .srst(srst), .ce(ce),
        .link(link), .addr_strap_high(2'b10), .addr_strap_low(2'b01), .multiplex_clock_in(mclk),
        .digit_sel(digit_sel), .seg_pattern_r(seg_pattern_r), .font_index_r(font_index_r),
        .font_valid_r(font_valid_r), .char_mode_r(char_mode_r), .dp_r(dp_r), .display_on(display_on),
        .intensity_mode(intensity_mode), .blink_phase(blink_phase), .slot_kind(slot_kind));
    ldm_link_properties i_ldm_link_properties (.clock(clock), .srst(srst), .scl(link.scl), .sda(link.sda),
        .host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe));
    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic finish_test();
        if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // one host transfer, waits for the end pulse under a bound
    task automatic xfer(input logic rd, input logic [6:0] sl, input logic [7:0] rg, input logic [7:0] wd);
        int n;
        @(posedge clock);
        #1 cmd_valid = 1'b1;
        cmd_read = rd;
        cmd_slave = sl;
        cmd_reg = rg;
        cmd_wdata = wd;
        // ready is read off the edge, so the edge that follows takes the request
        while (cmd_ready !== 1'b1) @(posedge clock) #1;
        @(posedge clock);
        #1 cmd_valid = 1'b0;
        for (n = 0; n < 20000 && rsp_valid_r !== 1'b1; n++) @(posedge clock) #1;
        if (n == 20000) chk("transfer end", 8'h01, 8'h00);
    endtask : xfer
    task automatic t_reset_values();
        xfer(1'b1, 7'h69, {1'b0, REG_CONFIG}, 8'h00);
        chk("config after reset", 8'h00, rsp_data_r);
        chk("nack on read", 8'h00, {7'h00, rsp_nack_r});
        chk("display on", 8'h00, {7'h00, display_on});
    endtask : t_reset_values
    task automatic t_config();
        xfer(1'b0, 7'h69, {1'b1, REG_CONFIG}, 8'hFF);
        chk("intensity mode", 8'h01, {7'h00, intensity_mode});
        xfer(1'b1, 7'h69, {1'b0, REG_CONFIG}, 8'h00);
        chk("config read", 8'h4D, rsp_data_r);
    endtask : t_config
    task automatic t_kind();
        xfer(1'b0, 7'h69, {1'b0, REG_KIND}, 8'hA5);
        chk("slot kind", 8'hA5, slot_kind);
        xfer(1'b1, 7'h69, {1'b0, REG_KIND}, 8'h00);
        chk("slot kind read", 8'h00, rsp_data_r);
    endtask : t_kind
    task automatic t_wrong_slave();
        xfer(1'b0, 7'h68, {1'b0, REG_DECODE}, 8'hFF);
        chk("foreign slave nack", 8'h01, {7'h00, rsp_nack_r});
    endtask : t_wrong_slave
    task automatic t_glyph();
        xfer(1'b0, 7'h69, 8'h20, 8'hC1);
        repeat (3) @(posedge clock);
        #1 chk("glyph index", 8'h29, {1'b0, font_index_r});
        chk("glyph flags", 8'h07, {5'h00, char_mode_r, font_valid_r, dp_r});
    endtask : t_glyph
    // blank in plane one, then two counted and two frozen multiplex clock rises
    task automatic t_blink();
        xfer(1'b0, 7'h69, 8'h40, 8'h20);
        for (int k = 0; k < 4; k++) begin
            ce = (k < 2);
            @(posedge clock);
            #1 mclk = 1'b1;
            @(posedge clock);
            #1 mclk = 1'b0;
        end
        ce = 1'b1;
        repeat (2) @(posedge clock);
        #1 chk("blink phase", 8'h01, {7'h00, blink_phase});
        chk("blank plane flags", 8'h04, {5'h00, char_mode_r, font_valid_r, dp_r});
        digit_sel = 4'h1;
        repeat (2) @(posedge clock);
        #1 chk("direct segments", 8'h20, seg_pattern_r);
        xfer(1'b1, 7'h69, {1'b0, REG_CONFIG}, 8'h00);
        chk("phase read", 8'hCD, rsp_data_r);
    endtask : t_blink
    // watchdog
    initial begin
        #3600000;
        miscompares++;
        finish_test();
    end
    // main sequence
    initial begin
        srst = 1'b1;
        {cmd_valid, cmd_read, cmd_slave, cmd_reg, cmd_wdata, mclk, digit_sel} = '0;
        ce = 1'b1;
        repeat (16) @(posedge clock);
        #1 srst = 1'b0;
        t_reset_values();
        t_config();
        t_kind();
        t_wrong_slave();
        t_glyph();
        t_blink();
        finish_test();
    end
endmodule : tb_top
